//--- common/pmsr_cfg.svh
// Register map, field positions, reset values and local register offsets of the status readback bank.
// How it works
// - 2.5 V, 3.3 V ready flags, reset one
// - Passthrough flag bit 0, reset zero
// - All-rails-ready bit is AND of the -10, 8.5 and 16 V rails, not 18 V
// - Per-rail ready flags, all reset zero
// - Mirror control inputs shown in bits 3:0
// - Boost bit 7, buck bit 6, boost reset
// - Overvoltage bit 5, undervoltage bit 4, live
// - Negative limit bit 3, positive bit 2
// - Start-up done flag bit 0, reset zero
// - Battery sample low bytes per subframe
// - Battery upper bits packed blue green red
// - Anode sample low bytes per subframe
// - Anode upper bits packed at 0x50
`ifndef PMSR_CFG_SVH
`define PMSR_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PMSR_ADDR_W 8
`define PMSR_OFF_LINREG 8'h43
`define PMSR_OFF_HVRAIL 8'h44
`define PMSR_OFF_MIRCTL 8'h45
`define PMSR_OFF_CONV 8'h48
`define PMSR_OFF_BAT_RED 8'h49
`define PMSR_OFF_BAT_GREEN 8'h4a
`define PMSR_OFF_BAT_BLUE 8'h4b
`define PMSR_OFF_BAT_HIGH 8'h4c
`define PMSR_OFF_AN_RED 8'h4d
`define PMSR_OFF_AN_GREEN 8'h4e
`define PMSR_OFF_AN_BLUE 8'h4f
`define PMSR_OFF_AN_HIGH 8'h50
`define PMSR_OFF_EVT_STAT 8'h58
`define PMSR_OFF_EVT_MASK 8'h59

// ****************************************
// Field positions
// ****************************************
`define PMSR_LIN_2V5_BIT 7
`define PMSR_LIN_3V3_BIT 5
`define PMSR_LIN_PT_BIT 0
`define PMSR_HV_ALL_BIT 6
`define PMSR_HV_M10_BIT 5
`define PMSR_HV_8V5_BIT 4
`define PMSR_HV_16_BIT 2
`define PMSR_HV_18_BIT 0
`define PMSR_CV_BOOST_BIT 7
`define PMSR_CV_BUCK_BIT 6
`define PMSR_CV_OV_BIT 5
`define PMSR_CV_UV_BIT 4
`define PMSR_CV_NCL_BIT 3
`define PMSR_CV_PCL_BIT 2
`define PMSR_CV_RDY_BIT 0

// ****************************************
// Reset values
// ****************************************
`define PMSR_RST_LINREG 8'ha0
`define PMSR_RST_CONV 8'h80
`define PMSR_RST_ZERO 8'h00

`endif

//--- common/pmsr_pkg.sv
// Types shared by the status readback bank.
package pmsr_pkg;
  typedef logic [7:0] pmsr_byte_type;
  typedef logic [9:0] pmsr_sample_type;
  typedef enum logic [1:0] {
    PMSR_CH_RED = 2'h0,
    PMSR_CH_GREEN = 2'h1,
    PMSR_CH_BLUE = 2'h2
  } pmsr_channel_type;
endpackage : pmsr_pkg

//--- verilog/pmsr_status_readback.sv
// Power status and subframe sample register bank, read-only except the event mask, with event interrupt.
//
// Local design decision: the strobed register port.
`include "pmsr_cfg.svh"

module pmsr_status_readback
  import pmsr_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 10,
  parameter int unsigned CHANNELS = 3
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Regulator and rail status from analog
  input wire logic reg_2v5_ready_in,
  input wire logic reg_3v3_ready_in,
  input wire logic reg_3v3_passthrough_in,
  input wire logic minus_ten_rail_ready_in,
  input wire logic eight_half_rail_ready_in,
  input wire logic sixteen_volt_rail_ready_in,
  input wire logic eighteen_volt_rail_ready_in,
  // Mirror-array control pins
  input wire logic neg_high_voltage_enable_in,
  input wire logic mid_voltage_enable_in,
  input wire logic array_enable_in,
  input wire logic emulation_reset_in,
  // Converter status from analog
  input wire logic converter_boost_in,
  input wire logic converter_buck_in,
  input wire logic converter_output_overvoltage_in,
  input wire logic converter_output_undervoltage_in,
  input wire logic converter_negative_current_limit_in,
  input wire logic converter_positive_current_limit_in,
  input wire logic converter_startup_done_in,
  // Sample converter results, same clock, one-cycle valid
  input wire logic sample_valid_in,
  input wire logic sample_is_anode_in,
  input wire logic [1:0] sample_channel_in,
  input wire logic [9:0] sample_data_in,
  // Interrupt
  output logic irq_out
);

  // ****************************************
  // Parameter checks
  // ****************************************
  // The packed high-bit registers have room for exactly two bits of three channels.
  if (SAMPLE_W != 10) begin : g_bad_width
    $error("pmsr_status_readback supports only ten-bit samples");
  end

  if (CHANNELS != 3) begin : g_bad_channels
    $error("pmsr_status_readback supports only three channels");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  // All analog flags are asynchronous to the clock; each passes two flops.
  localparam int unsigned NSYNC = 18;
  logic [NSYNC-1:0] async_raw;
  logic [NSYNC-1:0] sync_meta;
  logic [NSYNC-1:0] sync_q;

  assign async_raw = {reg_2v5_ready_in, reg_3v3_ready_in, reg_3v3_passthrough_in,
                      minus_ten_rail_ready_in, eight_half_rail_ready_in,
                      sixteen_volt_rail_ready_in, eighteen_volt_rail_ready_in,
                      neg_high_voltage_enable_in, mid_voltage_enable_in,
                      array_enable_in, emulation_reset_in,
                      converter_boost_in, converter_buck_in,
                      converter_output_overvoltage_in, converter_output_undervoltage_in,
                      converter_negative_current_limit_in, converter_positive_current_limit_in,
                      converter_startup_done_in};

  // Reset values of the synchronised flags follow the documented register defaults.
  localparam logic [NSYNC-1:0] SYNC_RST = 18'h30040;

  // Only the second flop of each pair is read by the logic below.
  for (genvar b = 0; b < NSYNC; b++) begin : g_sync
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        sync_meta[b] <= SYNC_RST[b];
        sync_q[b] <= SYNC_RST[b];
      end else begin
        sync_meta[b] <= async_raw[b];
        sync_q[b] <= sync_meta[b];
      end
    end
  end

  // ****************************************
  // Synchronised flag positions
  // ****************************************
  localparam int unsigned SY_2V5 = 17;
  localparam int unsigned SY_3V3 = 16;
  localparam int unsigned SY_PT = 15;
  localparam int unsigned SY_M10 = 14;
  localparam int unsigned SY_8V5 = 13;
  localparam int unsigned SY_16 = 12;
  localparam int unsigned SY_18 = 11;
  localparam int unsigned SY_NHV = 10;
  localparam int unsigned SY_MID = 9;
  localparam int unsigned SY_ARR = 8;
  localparam int unsigned SY_EMU = 7;
  localparam int unsigned SY_BOOST = 6;
  localparam int unsigned SY_BUCK = 5;
  localparam int unsigned SY_OV = 4;
  localparam int unsigned SY_UV = 3;
  localparam int unsigned SY_NCL = 2;
  localparam int unsigned SY_PCL = 1;
  localparam int unsigned SY_RDY = 0;

  logic s_2v5;
  logic s_3v3;
  logic s_pt;
  logic s_m10;
  logic s_8v5;
  logic s_16;
  logic s_18;
  logic s_nhv;
  logic s_mid;
  logic s_arr;
  logic s_emu;
  logic s_boost;
  logic s_buck;
  logic s_ov;
  logic s_uv;
  logic s_ncl;
  logic s_pcl;
  logic s_rdy;

  assign s_2v5 = sync_q[SY_2V5];
  assign s_3v3 = sync_q[SY_3V3];
  assign s_pt = sync_q[SY_PT];
  assign s_m10 = sync_q[SY_M10];
  assign s_8v5 = sync_q[SY_8V5];
  assign s_16 = sync_q[SY_16];
  assign s_18 = sync_q[SY_18];
  assign s_nhv = sync_q[SY_NHV];
  assign s_mid = sync_q[SY_MID];
  assign s_arr = sync_q[SY_ARR];
  assign s_emu = sync_q[SY_EMU];
  assign s_boost = sync_q[SY_BOOST];
  assign s_buck = sync_q[SY_BUCK];
  assign s_ov = sync_q[SY_OV];
  assign s_uv = sync_q[SY_UV];
  assign s_ncl = sync_q[SY_NCL];
  assign s_pcl = sync_q[SY_PCL];
  assign s_rdy = sync_q[SY_RDY];

  // ****************************************
  // Status register images
  // ****************************************
  pmsr_byte_type linreg;
  pmsr_byte_type hvrail;
  pmsr_byte_type mirctl;
  pmsr_byte_type conv;

  always_comb begin
    linreg = `PMSR_RST_ZERO;
    linreg[`PMSR_LIN_2V5_BIT] = s_2v5;
    linreg[`PMSR_LIN_3V3_BIT] = s_3v3;
    linreg[`PMSR_LIN_PT_BIT] = s_pt;
  end

  always_comb begin
    hvrail = `PMSR_RST_ZERO;
    hvrail[`PMSR_HV_M10_BIT] = s_m10;
    hvrail[`PMSR_HV_8V5_BIT] = s_8v5;
    hvrail[`PMSR_HV_16_BIT] = s_16;
    hvrail[`PMSR_HV_18_BIT] = s_18;
    hvrail[`PMSR_HV_ALL_BIT] = s_16 & s_8v5 & s_m10;
  end

  assign mirctl = {4'h0, s_nhv, s_mid, s_arr, s_emu};

  always_comb begin
    conv = `PMSR_RST_ZERO;
    conv[`PMSR_CV_BOOST_BIT] = s_boost;
    conv[`PMSR_CV_BUCK_BIT] = s_buck;
    conv[`PMSR_CV_OV_BIT] = s_ov;
    conv[`PMSR_CV_UV_BIT] = s_uv;
    conv[`PMSR_CV_NCL_BIT] = s_ncl;
    conv[`PMSR_CV_PCL_BIT] = s_pcl;
    conv[`PMSR_CV_RDY_BIT] = s_rdy;
  end

  // ****************************************
  // Subframe sample storage
  // ****************************************
  // Each sample is written whole in one cycle, so a read sees either the old or the new value.
  pmsr_sample_type bat_smp [CHANNELS];
  pmsr_sample_type an_smp [CHANNELS];

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_smp
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        bat_smp[ch] <= '0;
        an_smp[ch] <= '0;
      end else if (sample_valid_in && sample_channel_in == 2'(ch)) begin
        if (sample_is_anode_in) begin
          an_smp[ch] <= sample_data_in;
        end else begin
          bat_smp[ch] <= sample_data_in;
        end
      end
    end
  end

  pmsr_byte_type bat_high;
  pmsr_byte_type an_high;
  assign bat_high = {2'h0, bat_smp[PMSR_CH_BLUE][9:8], bat_smp[PMSR_CH_GREEN][9:8],
                     bat_smp[PMSR_CH_RED][9:8]};
  assign an_high = {2'h0, an_smp[PMSR_CH_BLUE][9:8], an_smp[PMSR_CH_GREEN][9:8],
                    an_smp[PMSR_CH_RED][9:8]};

  // ****************************************
  // Events and interrupt
  // ****************************************
  // Events: bit0 rail lost, bit1 overvoltage, bit2 undervoltage, bit3 current limit,
  // bit4 new battery sample, bit5 new anode sample.
  logic [5:0] evt_stat;
  logic [5:0] evt_mask;
  logic [5:0] evt_now;
  logic all_rails_q;
  logic all_rails;
  logic evt_rail_lost;
  logic evt_over;
  logic evt_under;
  logic evt_limit;
  logic evt_bat;
  logic evt_an;
  logic stat_clear;

  assign all_rails = s_2v5 & s_3v3 & s_16 & s_8v5 & s_m10 & s_18;
  // The edge detector resets low and the rails reset not ready, so no false loss follows reset.
  assign evt_rail_lost = all_rails_q & ~all_rails;
  assign evt_over = s_ov;
  assign evt_under = s_uv;
  assign evt_limit = s_ncl | s_pcl;
  assign evt_bat = sample_valid_in & ~sample_is_anode_in;
  assign evt_an = sample_valid_in & sample_is_anode_in;
  assign evt_now = {evt_an, evt_bat, evt_limit, evt_under, evt_over, evt_rail_lost};
  assign stat_clear = rd_in && (addr_in == `PMSR_OFF_EVT_STAT);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      all_rails_q <= 1'b0;
    end else begin
      all_rails_q <= all_rails;
    end
  end

  // A read clears the status, but an event in the same cycle still lands, so none is lost.
  for (genvar e = 0; e < 6; e++) begin : g_evt
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        evt_stat[e] <= 1'b0;
      end else if (evt_now[e]) begin
        evt_stat[e] <= 1'b1;
      end else if (stat_clear) begin
        evt_stat[e] <= 1'b0;
      end
    end
  end

  // The mask is the only writable register; a set bit enables that event.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      evt_mask <= '0;
    end else if (wr_in && addr_in == `PMSR_OFF_EVT_MASK) begin
      evt_mask <= wdata_in[5:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_stat & evt_mask);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Writes to status addresses are decoded nowhere, so they cannot disturb state.
  pmsr_byte_type next_rdata;

  always_comb begin
    case (addr_in)
      `PMSR_OFF_LINREG: begin
        next_rdata = linreg;
      end
      `PMSR_OFF_HVRAIL: begin
        next_rdata = hvrail;
      end
      `PMSR_OFF_MIRCTL: begin
        next_rdata = mirctl;
      end
      `PMSR_OFF_CONV: begin
        next_rdata = conv;
      end
      `PMSR_OFF_BAT_RED: begin
        next_rdata = bat_smp[PMSR_CH_RED][7:0];
      end
      `PMSR_OFF_BAT_GREEN: begin
        next_rdata = bat_smp[PMSR_CH_GREEN][7:0];
      end
      `PMSR_OFF_BAT_BLUE: begin
        next_rdata = bat_smp[PMSR_CH_BLUE][7:0];
      end
      `PMSR_OFF_BAT_HIGH: begin
        next_rdata = bat_high;
      end
      `PMSR_OFF_AN_RED: begin
        next_rdata = an_smp[PMSR_CH_RED][7:0];
      end
      `PMSR_OFF_AN_GREEN: begin
        next_rdata = an_smp[PMSR_CH_GREEN][7:0];
      end
      `PMSR_OFF_AN_BLUE: begin
        next_rdata = an_smp[PMSR_CH_BLUE][7:0];
      end
      `PMSR_OFF_AN_HIGH: begin
        next_rdata = an_high;
      end
      `PMSR_OFF_EVT_STAT: begin
        next_rdata = {2'h0, evt_stat};
      end
      `PMSR_OFF_EVT_MASK: begin
        next_rdata = {2'h0, evt_mask};
      end
      default: begin
        // Unmapped offsets read as zero rather than aliasing a neighbour.
        next_rdata = `PMSR_RST_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= `PMSR_RST_ZERO;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= `PMSR_RST_ZERO;
    end
  end

endmodule : pmsr_status_readback

//--- tb/pmsr_host_model.sv
// Host model that reaches the status bank over its register port.
module pmsr_host_model (
  // Clock and read data
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  // Request signals
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
  endtask : write
  // Data stands only in the cycle after the strobe, so it is taken just past that edge.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask : read
endmodule : pmsr_host_model

//--- tb/pmsr_status_readback_monitor.sv
// Port checker for the status readback bank.
module pmsr_status_readback_mon
  import pmsr_pkg::*;
#(parameter int unsigned SAMPLE_W = 10, parameter int unsigned CHANNELS = 3) (
  input wire logic ref_clk_in, resetn_in, wr_in, rd_in, irq_out, sample_valid_in, sample_is_anode_in,
  input wire logic neg_high_voltage_enable_in, mid_voltage_enable_in, array_enable_in, emulation_reset_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out,
  input wire logic [1:0] sample_channel_in,
  input wire logic [9:0] sample_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mir;
  logic [2:0] up;
  logic [7:0] rmask;
  assign mir = {neg_high_voltage_enable_in, mid_voltage_enable_in, array_enable_in, emulation_reset_in};
  // Pins pass two synchronising flops, so mirror checks need settled history after reset.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  always_comb begin
    case (addr_in)
      8'h43: rmask = 8'h5e;
      8'h44: rmask = 8'h8a;
      8'h45: rmask = 8'hf0;
      8'h48: rmask = 8'h02;
      8'h4c, 8'h50: rmask = 8'hc0;
      default: rmask = 8'h00;
    endcase
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_idle_read_zero: assert property (!rd_in |=> rdata_out == 8'h00) else $error("data outside read");
  a_mirror_pins: assert property (up > 3'h4 && rd_in && addr_in == 8'h45 && mir == $past(mir)
    && mir == $past(mir, 2) && mir == $past(mir, 3) |=> rdata_out == {4'h0, $past(mir)}) else $error("mirror");
  a_rails_all_ready: assert property (rd_in && addr_in == 8'h44 |=>
    rdata_out[6] == (rdata_out[5] & rdata_out[4] & rdata_out[2])) else $error("all ready bit");
  a_reserved_bits_zero: assert property (rd_in |=> (rdata_out & $past(rmask)) == 8'h00)
    else $error("reserved bit set");
  a_battery_red_store: assert property (sample_valid_in && !sample_is_anode_in && sample_channel_in == 2'h0
    ##1 rd_in && addr_in == 8'h49 && !sample_valid_in |=> rdata_out == $past(sample_data_in[7:0], 2))
    else $error("red battery sample");
  a_anode_blue_store: assert property (sample_valid_in && sample_is_anode_in && sample_channel_in == 2'h2
    ##1 rd_in && addr_in == 8'h4f && !sample_valid_in |=> rdata_out == $past(sample_data_in[7:0], 2))
    else $error("blue anode sample");
  a_irq_masked_off: assert property (wr_in && addr_in == 8'h59 && wdata_in[5:0] == 6'h00 |=> ##1 !irq_out)
    else $error("irq with empty mask");
  a_mask_read_back: assert property (wr_in && addr_in == 8'h59 ##1 !wr_in ##1 rd_in && addr_in == 8'h59
    |=> rdata_out == {2'b00, $past(wdata_in[5:0], 3)}) else $error("mask readback");
endmodule : pmsr_status_readback_mon

bind pmsr_status_readback pmsr_status_readback_mon #(.SAMPLE_W(SAMPLE_W), .CHANNELS(CHANNELS)) mon_u (.*);

//--- tb/test_pmsr_status_readback.sv
// Self-checking bench for the status readback bank.
module test_pmsr_status_readback;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, sv, sa, irq;
  logic [17:0] st;
  logic [1:0] sc;
  logic [9:0] sd;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic [5:0] msk;
  logic [9:0] bat [3];
  logic [9:0] an [3];
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  pmsr_host_model host_u (.ref_clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd));
  pmsr_status_readback dut_u (.ref_clk_in(clk), .resetn_in(resetn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .reg_2v5_ready_in(st[0]), .reg_3v3_ready_in(st[1]),
    .reg_3v3_passthrough_in(st[2]), .minus_ten_rail_ready_in(st[3]), .eight_half_rail_ready_in(st[4]),
    .sixteen_volt_rail_ready_in(st[5]), .eighteen_volt_rail_ready_in(st[6]), .emulation_reset_in(st[7]),
    .array_enable_in(st[8]), .mid_voltage_enable_in(st[9]), .neg_high_voltage_enable_in(st[10]),
    .converter_startup_done_in(st[11]), .converter_positive_current_limit_in(st[12]),
    .converter_negative_current_limit_in(st[13]), .converter_output_undervoltage_in(st[14]),
    .converter_output_overvoltage_in(st[15]), .converter_buck_in(st[16]), .converter_boost_in(st[17]),
    .sample_valid_in(sv), .sample_is_anode_in(sa), .sample_channel_in(sc), .sample_data_in(sd), .irq_out(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sv) sv <= 1'b0;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  function automatic logic [7:0] expv(input logic [7:0] a);
    case (a)
      8'h43: return {st[0], 1'b0, st[1], 4'h0, st[2]};
      8'h44: return {1'b0, &st[5:3], st[3], st[4], 1'b0, st[5], 1'b0, st[6]};
      8'h45: return {4'h0, st[10:7]};
      8'h48: return {st[17:12], 1'b0, st[11]};
      8'h49, 8'h4a, 8'h4b: return bat[a - 8'h49][7:0];
      8'h4c: return {2'b00, bat[2][9:8], bat[1][9:8], bat[0][9:8]};
      8'h4d, 8'h4e, 8'h4f: return an[a - 8'h4d][7:0];
      8'h50: return {2'b00, an[2][9:8], an[1][9:8], an[0][9:8]};
      8'h59: return {2'b00, msk};
      default: return 8'h00;
    endcase
  endfunction : expv
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // Every offset from 0x43 to 0x50 is first written with noise, which must leave its contents alone.
  task automatic sweep();
    logic [7:0] v;
    for (int a = 8'h43; a <= 8'h50; a++) begin
      host_u.write(8'(a), 8'($urandom));
      host_u.read(8'(a), v);
      chk(v, expv(8'(a)));
    end
  endtask : sweep
  task automatic samp(input logic k, input logic [1:0] c, input logic [9:0] v);
    logic [7:0] a;
    logic [7:0] r;
    a = (k ? 8'h4d : 8'h49) + {6'h00, c};
    @(posedge clk);
    sv <= 1'b1;
    sa <= k;
    sc <= c;
    sd <= v;
    if (c != 2'h3 && k) an[c] = v;
    if (c != 2'h3 && !k) bat[c] = v;
    host_u.read(a, r);
    chk(r, expv(a));
    sweep();
  endtask : samp
  initial begin
    st = 18'h20003;
    {sv, sa, sc, sd, msk, resetn} = '0;
    foreach (bat[i]) {bat[i], an[i]} = '0;
    void'($urandom(32'hc97273af));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    sweep();
    repeat (8) begin
      @(posedge clk) st <= 18'($urandom);
      repeat (3) @(posedge clk);
      sweep();
    end
    repeat (12) samp(1'($urandom), 2'($urandom), 10'($urandom));
    @(posedge clk) st <= 18'h20003;
    repeat (3) @(posedge clk);
    host_u.write(8'h59, 8'hd0);
    msk = 6'h10;
    host_u.read(8'h58, d);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    samp(1'b0, 2'h1, 10'h2a5);
    chk({7'h0, irq}, 8'h01);
    host_u.write(8'h59, 8'h00);
    msk = 6'h00;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    host_u.write(8'h59, 8'h10);
    msk = 6'h10;
    host_u.read(8'h59, d);
    chk(d, expv(8'h59));
    chk({7'h0, irq}, 8'h01);
    host_u.read(8'h58, d);
    chk(d & 8'h10, 8'h10);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    host_u.write(8'h59, 8'h20);
    msk = 6'h20;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    samp(1'b1, 2'h2, 10'h1c3);
    chk({7'h0, irq}, 8'h01);
    summarize();
  end
endmodule : test_pmsr_status_readback
